// >>> logic/i2c_seq_pkg.sv
package i2c_seq_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] REG_BUFFER = 3'h0;
  localparam logic [2:0] REG_RELOAD = 3'h1;
  localparam logic [2:0] REG_CTRL_TWO = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_ENABLE = 3'h4;
  // Bit positions in control_reg_two
  localparam int START_BIT = 0;
  localparam int RESTART_BIT = 1;
  localparam int RECEIVE_BIT = 3;
  localparam int PEER_ACK_BIT = 6;
  // Bit positions in port_status_reg
  localparam int BF_BIT = 0;
  localparam int START_SEEN_BIT = 3;
  localparam int WRITE_COLLISION_FLAG_BIT = 4;
  localparam int OVF_BIT = 5;
  localparam int IRQ_BIT = 6;
  localparam int BCOL_BIT = 7;
  // Reset values, bits per byte and synchronizer depth
  localparam logic [7:0] RELOAD_RESET = 8'h09;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_START_A = 10'h002,
    ST_START_B = 10'h004,
    ST_RS_LOW = 10'h008,
    ST_RS_SDA = 10'h010,
    ST_RS_SCLW = 10'h020,
    ST_RS_HIGH = 10'h040,
    ST_RS_HOLD = 10'h080,
    ST_TX = 10'h100,
    ST_RX = 10'h200
  } seq_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } bus_in_t;
endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import i2c_seq_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic pinIn,
  output logic pinLevel
);
  logic [SYNC_STAGES-1:0] stage_q;

  initial
  begin
    if (SYNC_STAGES != 3)
    begin
      $error("pin_sync needs three stages");
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      stage_q <= {SYNC_STAGES{RESET_LEVEL}};
    end
    else
    begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], pinIn};
    end
  end

  // Change counts only when stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pinLevel <= RESET_LEVEL;
    end
    else if (stage_q[1] == stage_q[2])
    begin
      pinLevel <= stage_q[2];
    end
  end
endmodule

// >>> logic/rate_gen.sv
`timescale 1ns/1ps
module rate_gen
  import i2c_seq_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic run,
  input wire logic [WIDTH-1:0] reloadVal,
  output logic tick
);
  logic [WIDTH+1:0] count_q;

  initial
  begin
    if (WIDTH < 1 || WIDTH > 16)
    begin
      $error("rate_gen width out of range");
    end
  end

  // Period is four times (reload plus one)
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      count_q <= '0;
    end
    else if (load)
    begin
      count_q <= {reloadVal, 2'b11};
    end
    else if (run && count_q != '0)
    begin
      count_q <= count_q - 1'b1;
    end
  end

  assign tick = run && !load && count_q == '0;
endmodule

// >>> logic/i2c_master_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - Start: both high, load reload low seven
// - Timeout with both high: pull data, flag
// - Reload full byte, then end start
// - Low line at start: collision, idle
// - Buffer write during start: write collision
// - Control low five blocked until start done
// - Restart: pull clock, then release data
// - Release clock, both high, data low
// - Clear restart; irq after final timeout
// - Restart ignored while busy
// - Restart collision on data or clock
// - Restart blocks buffer and control writes
// - Buffer write sets full, starts shifting
// - After eighth bit clear full, release
// - Ninth fall samples peer acknowledge
// - After ninth set irq, hold clock low
// - Write during shift: write collision
// - Receive request ignored unless idle
// - Receive toggles clock, shifts data
// - Eighth fall: buffer, full, irq set
// - Byte while full: overflow flag
// - Each clock phase but a start's first and a byte's first low phase, timed from reload low seven, lasts four(reload+1) oscillator cycles or more
module i2c_master_sequencer
  import i2c_seq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire bus_in_t busIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe
);
  seq_state_t state_q;
  logic [7:0] reload_q, buffer_q, shift_q;
  logic [3:0] bitCnt_q;
  logic phaseHigh_q, ackPhase_q, sclDrive_q, sdaDrive_q;
  logic enable_q, startReq_q, restartReq_q, rxReq_q, peerAck_q;
  logic bufFull_q, startSeen_q, write_collision_flag_q, ovf_q, irq_q, bcol_q;
  logic scl, sda, sclPrev_q, tick, load, run, reloadLow, reloadPend_q;
  logic [7:0] loadVal;
  logic bufWr, bufRd, ctrlWr, statWr, busy;

  pin_sync u_scl (.sys_clk(sys_clk), .rstn(rstn), .pinIn(busIn.sclIn), .pinLevel(scl));
  pin_sync u_sda (.sys_clk(sys_clk), .rstn(rstn), .pinIn(busIn.sdaIn), .pinLevel(sda));

  assign loadVal = reloadLow ? {1'b0, reload_q[6:0]} : reload_q;
  rate_gen #(.WIDTH(8)) u_brg (
    .sys_clk(sys_clk), .rstn(rstn), .load(load), .run(run),
    .reloadVal(loadVal), .tick(tick)
  );

  assign busy = state_q != ST_IDLE;
  assign bufWr = regReq.wr && regReq.addr == REG_BUFFER;
  assign bufRd = regReq.rd && regReq.addr == REG_BUFFER;
  assign ctrlWr = regReq.wr && regReq.addr == REG_CTRL_TWO;
  assign statWr = regReq.wr && regReq.addr == REG_STATUS;

  // Lines idle high; open drain drives only low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclDrive_q;
  assign sdaOe = sdaDrive_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sclPrev_q <= 1'b1;
    end
    else
    begin
      sclPrev_q <= scl;
    end
  end

  // Fresh period for each low or hold phase; a registered request keeps load off the tick path
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !enable_q)
    begin
      reloadPend_q <= 1'b0;
    end
    else
    begin
      reloadPend_q <= tick && (state_q == ST_START_A || state_q == ST_RS_HIGH
        || ((state_q == ST_TX || state_q == ST_RX) && phaseHigh_q));
    end
  end

  // Generator steering
  always_comb
  begin
    load = 1'b0;
    run = 1'b0;
    reloadLow = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        load = startReq_q && scl && sda;
        reloadLow = 1'b1;
        if (!load && enable_q && bufWr && !bufFull_q && !write_collision_flag_q)
        begin
          load = 1'b1;
        end
        if (!load && enable_q && ctrlWr && regReq.wdata[RECEIVE_BIT])
        begin
          load = 1'b1;
        end
      end
      ST_START_A, ST_START_B, ST_RS_SDA, ST_RS_HIGH, ST_RS_HOLD:
      begin
        run = 1'b1;
        load = reloadPend_q && (state_q == ST_START_B || state_q == ST_RS_HOLD);
      end
      ST_RS_LOW:
      begin
        load = !scl;
      end
      ST_RS_SCLW:
      begin
        load = scl;
      end
      ST_TX, ST_RX:
      begin
        // Clock stretching: wait while a released clock is held low
        run = sclDrive_q || scl;
        load = (!sclDrive_q && scl && !sclPrev_q) || reloadPend_q;
      end
      default:
      begin
        load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      reload_q <= RELOAD_RESET;
      enable_q <= 1'b0;
    end
    else if (regReq.wr && regReq.addr == REG_RELOAD)
    begin
      reload_q <= regReq.wdata;
    end
    else if (regReq.wr && regReq.addr == REG_ENABLE)
    begin
      enable_q <= regReq.wdata[0];
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !enable_q)
    begin
      state_q <= ST_IDLE;
      sclDrive_q <= 1'b0;
      sdaDrive_q <= 1'b0;
      startReq_q <= 1'b0;
      restartReq_q <= 1'b0;
      rxReq_q <= 1'b0;
      bitCnt_q <= 4'h0;
      phaseHigh_q <= 1'b0;
      ackPhase_q <= 1'b0;
      shift_q <= BYTE_RESET;
      peerAck_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (ctrlWr && !startReq_q && !restartReq_q)
          begin
            startReq_q <= regReq.wdata[START_BIT];
            restartReq_q <= regReq.wdata[RESTART_BIT];
          end
          if (startReq_q)
          begin
            if (scl && sda)
            begin
              state_q <= ST_START_A;
            end
            else
            begin
              startReq_q <= 1'b0;
            end
          end
          else if (restartReq_q)
          begin
            sclDrive_q <= 1'b1;
            state_q <= ST_RS_LOW;
          end
          else if (load && bufWr)
          begin
            shift_q <= regReq.wdata;
            bitCnt_q <= 4'h0;
            phaseHigh_q <= 1'b0;
            ackPhase_q <= 1'b0;
            sclDrive_q <= 1'b1;
            sdaDrive_q <= !regReq.wdata[7];
            state_q <= ST_TX;
          end
          else if (load && ctrlWr)
          begin
            rxReq_q <= 1'b1;
            bitCnt_q <= 4'h0;
            phaseHigh_q <= 1'b0;
            sclDrive_q <= 1'b1;
            sdaDrive_q <= 1'b0;
            state_q <= ST_RX;
          end
        end
        ST_START_A:
        begin
          if (!scl)
          begin
            startReq_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (tick)
          begin
            sdaDrive_q <= 1'b1;
            state_q <= ST_START_B;
          end
        end
        ST_START_B:
        begin
          if (tick)
          begin
            startReq_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_RS_LOW:
        begin
          if (!scl)
          begin
            sdaDrive_q <= 1'b0;
            state_q <= ST_RS_SDA;
          end
        end
        ST_RS_SDA:
        begin
          if (tick && sda)
          begin
            sclDrive_q <= 1'b0;
            state_q <= ST_RS_SCLW;
          end
        end
        ST_RS_SCLW:
        begin
          if (scl && !sda)
          begin
            restartReq_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (scl)
          begin
            state_q <= ST_RS_HIGH;
          end
        end
        ST_RS_HIGH:
        begin
          if (!scl || !sda)
          begin
            restartReq_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (tick)
          begin
            sdaDrive_q <= 1'b1;
            state_q <= ST_RS_HOLD;
          end
        end
        ST_RS_HOLD:
        begin
          if (tick)
          begin
            restartReq_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_TX:
        begin
          if (tick && !phaseHigh_q)
          begin
            sclDrive_q <= 1'b0;
            phaseHigh_q <= 1'b1;
          end
          else if (tick)
          begin
            sclDrive_q <= 1'b1;
            phaseHigh_q <= 1'b0;
            if (ackPhase_q)
            begin
              peerAck_q <= sda;
              state_q <= ST_IDLE;
            end
            else if (bitCnt_q == BITS_PER_BYTE - 4'h1)
            begin
              sdaDrive_q <= 1'b0;
              ackPhase_q <= 1'b1;
            end
            else
            begin
              sdaDrive_q <= !shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_RX:
        begin
          if (tick)
          begin
            sclDrive_q <= !sclDrive_q;
            phaseHigh_q <= !phaseHigh_q;
            if (phaseHigh_q)
            begin
              shift_q <= {shift_q[6:0], sda};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == BITS_PER_BYTE - 4'h1)
              begin
                rxReq_q <= 1'b0;
                state_q <= ST_IDLE;
              end
            end
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  logic txDone, rxDone, rsDone, stDone, bcolEv, wcolEv;
  assign txDone = state_q == ST_TX && tick && phaseHigh_q && ackPhase_q;
  assign rxDone = state_q == ST_RX && tick && phaseHigh_q
    && bitCnt_q == BITS_PER_BYTE - 4'h1;
  assign rsDone = state_q == ST_RS_HOLD && tick;
  assign stDone = state_q == ST_START_B && tick;
  assign bcolEv = (state_q == ST_IDLE && startReq_q && !(scl && sda))
    || (state_q == ST_START_A && !scl)
    || (state_q == ST_RS_SCLW && scl && !sda)
    || (state_q == ST_RS_HIGH && (!scl || !sda));
  assign wcolEv = bufWr && (busy || startReq_q || restartReq_q);

  // Status flags; hardware set wins over software clear
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !enable_q)
    begin
      bufFull_q <= 1'b0;
      startSeen_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ovf_q <= 1'b0;
      irq_q <= 1'b0;
      bcol_q <= 1'b0;
      buffer_q <= BYTE_RESET;
    end
    else
    begin
      if (rxDone)
      begin
        buffer_q <= {shift_q[6:0], sda};
      end
      else if (bufWr && !wcolEv && !write_collision_flag_q)
      begin
        buffer_q <= regReq.wdata;
      end
      if (rxDone || (load && bufWr && !wcolEv && state_q == ST_IDLE))
      begin
        bufFull_q <= 1'b1;
      end
      else if ((state_q == ST_TX && ackPhase_q) || bufRd)
      begin
        bufFull_q <= 1'b0;
      end
      startSeen_q <= (tick && state_q == ST_START_A && scl && sda)
        || (state_q == ST_RS_HOLD) || (startSeen_q && !(statWr
        && !regReq.wdata[START_SEEN_BIT]));
      write_collision_flag_q <= wcolEv || (write_collision_flag_q && !(statWr && !regReq.wdata[WRITE_COLLISION_FLAG_BIT]));
      ovf_q <= (rxDone && bufFull_q)
        || (ovf_q && !(statWr && !regReq.wdata[OVF_BIT]));
      irq_q <= txDone || rxDone || rsDone || stDone
        || (irq_q && !(statWr && !regReq.wdata[IRQ_BIT]));
      bcol_q <= bcolEv || (bcol_q && !(statWr && !regReq.wdata[BCOL_BIT]));
    end
  end

  // Read data one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      regRdata <= 8'h00;
    end
    else if (regReq.rd)
    begin
      unique case (regReq.addr)
        REG_BUFFER: regRdata <= buffer_q;
        REG_RELOAD: regRdata <= reload_q;
        REG_CTRL_TWO: regRdata <= {1'b0, peerAck_q, 2'b00, rxReq_q, 1'b0,
          restartReq_q, startReq_q};
        REG_STATUS: regRdata <= {bcol_q, irq_q, ovf_q, write_collision_flag_q, startSeen_q,
          2'b00, bufFull_q};
        REG_ENABLE: regRdata <= {7'h00, enable_q};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  collision_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_START_A && !scl |=> bcol_q && state_q == ST_IDLE)
    else $error("start collision not flagged");
  start_pull_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_START_A && tick && scl && sda |=> sdaOe && startSeen_q)
    else $error("start did not pull data");
  write_collision_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    bufWr && busy && enable_q |=> write_collision_flag_q && $stable(buffer_q))
    else $error("write collision missed");
  ack_sample_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    txDone && enable_q |=> peerAck_q == $past(sda) && irq_q && sclOe)
    else $error("peer ack wrong");
  rx_done_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rxDone && enable_q |=> bufFull_q && irq_q && !rxReq_q)
    else $error("receive end wrong");
  overflow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rxDone && bufFull_q && enable_q |=> ovf_q)
    else $error("overflow missed");
  restart_pull_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_IDLE && restartReq_q && !startReq_q && enable_q |=> sclOe)
    else $error("restart clock not pulled");
  disable_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !enable_q |=> state_q == ST_IDLE && !sclOe && !sdaOe)
    else $error("disable not idle");
  cover_start_c: cover property (@(posedge sys_clk) stDone);
  cover_tx_c: cover property (@(posedge sys_clk) txDone);
  cover_rx_c: cover property (@(posedge sys_clk) rxDone);
  cover_rs_c: cover property (@(posedge sys_clk) rsDone);
endmodule

// >>> dv/i2c_slave_model.sv
`timescale 1ns/1ps
module i2c_slave_model
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic ackOn,
  input wire logic readOn,
  input wire logic [7:0] txByte,
  input wire logic holdScl,
  output logic sclPull,
  output logic sdaPull,
  output logic [7:0] rxByte
);
  logic sclLast;
  logic sdaLast;
  logic readPhase;
  logic [3:0] cnt;
  // Clock held low only when a scenario asks, to provoke a collision
  assign sclPull = holdScl;
  always_ff @(posedge sys_clk)
  begin
    sclLast <= scl;
    sdaLast <= sda;
    if (!rstn)
    begin
      cnt <= 4'h0;
      readPhase <= 1'b0;
      sdaPull <= 1'b0;
      rxByte <= 8'h00;
    end
    else if (scl && sclLast && sdaLast && !sda)
    begin
      cnt <= 4'h0;
      readPhase <= 1'b0;
      sdaPull <= 1'b0;
    end
    else if (scl && !sclLast)
    begin
      cnt <= cnt + 4'h1;
      if (!readPhase && cnt < 4'h8)
        rxByte <= {rxByte[6:0], sda};
    end
    else if (!scl && sclLast)
    begin
      // Data changes only while the clock is low
      if (readPhase)
      begin
        if (cnt == 4'h8)
          cnt <= 4'h0;
        sdaPull <= ~txByte[3'(4'h7 - (cnt & 4'h7))];
      end
      else if (cnt == 4'h8)
        sdaPull <= ackOn;
      else if (cnt == 4'h9)
      begin
        cnt <= 4'h0;
        readPhase <= readOn;
        sdaPull <= readOn & ~txByte[7];
      end
    end
  end
endmodule

// >>> dv/i2c_master_sequencer_tb_top.sv
`timescale 1ns/1ps
module i2c_master_sequencer_tb_top;
  import i2c_seq_pkg::*;
  typedef struct packed {logic [7:0] data; logic ack; logic restart; logic dbl;} row_t;
  row_t rows [4] = '{'{8'hA5, 1'b1, 1'b0, 1'b0}, '{8'h3C, 1'b0, 1'b1, 1'b0},
                     '{8'hFF, 1'b1, 1'b1, 1'b1}, '{8'h00, 1'b0, 1'b1, 1'b0}};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  reg_req_t regReq = '0;
  logic [7:0] regRdata;
  logic sclOut;
  logic sclOe;
  logic sdaOut;
  logic sdaOe;
  logic ackOn = 1'b0;
  logic readOn = 1'b0;
  logic holdScl = 1'b0;
  logic [7:0] txByte = 8'h5A;
  logic slvScl;
  logic slvSda;
  logic [7:0] rxByte;
  logic [7:0] rd;
  bus_in_t busIn;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  // Open-drain wires with pull-ups
  wire scl = ~(sclOe | slvScl);
  wire sda = ~(sdaOe | slvSda);
  assign busIn = '{sclIn: scl, sdaIn: sda};
  always #50 sys_clk = ~sys_clk;

  i2c_master_sequencer DUT (.sys_clk(sys_clk), .rstn(rstn), .regReq(regReq),
    .regRdata(regRdata), .busIn(busIn), .sclOut(sclOut), .sclOe(sclOe),
    .sdaOut(sdaOut), .sdaOe(sdaOe));
  i2c_slave_model slave (.sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda(sda),
    .ackOn(ackOn), .readOn(readOn), .txByte(txByte), .holdScl(holdScl),
    .sclPull(slvScl), .sdaPull(slvSda), .rxByte(rxByte));

  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic regRead(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1 d = regRdata;
  endtask

  // Polls status; a flag that never comes counts as a mismatch
  task automatic waitFlag(input int b);
    logic [7:0] s;
    int n;
    s = 8'h00;
    n = 0;
    while (s[b] !== 1'b1 && n < 300)
    begin
      regRead(REG_STATUS, s);
      n++;
    end
    if (s[b] !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR %0t flag %0d never set", $time, b);
    end
  endtask

  task automatic resetCheck();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk({6'h0, sclOe, sdaOe}, 8'h00);
    chk({6'h0, sclOut, sdaOut}, 8'h00);
    repeat (5) @(posedge sys_clk);
    regWrite(3'h7, 8'hFF);
    regRead(REG_RELOAD, rd);
    chk(rd, RELOAD_RESET);
    regRead(REG_STATUS, rd);
    chk(rd, 8'h00);
    regRead(REG_CTRL_TWO, rd);
    chk(rd, 8'h00);
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      $display("ERROR %0t run too long", $time);
      end_of_test();
    end
  end

  initial
  begin
    resetCheck();
    // Short reload keeps the run brief: one period is 16 cycles
    regWrite(REG_RELOAD, 8'h03);
    regWrite(REG_ENABLE, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      ackOn <= rows[i].ack;
      regWrite(REG_STATUS, 8'h00);
      regWrite(REG_CTRL_TWO, rows[i].restart ? 8'h02 : 8'h01);
      regWrite(REG_BUFFER, 8'h55);
      regWrite(REG_CTRL_TWO, 8'h08);
      waitFlag(IRQ_BIT);
      regRead(REG_STATUS, rd);
      chk({7'h0, rd[WRITE_COLLISION_FLAG_BIT]}, 8'h01);
      chk({7'h0, rd[START_SEEN_BIT]}, 8'h01);
      chk({7'h0, sdaOe}, 8'h01);
      regRead(REG_CTRL_TWO, rd);
      chk(rd & 8'h0B, 8'h00);
      regWrite(REG_STATUS, 8'h00);
      regWrite(REG_BUFFER, rows[i].data);
      regRead(REG_STATUS, rd);
      chk({7'h0, rd[BF_BIT]}, 8'h01);
      if (rows[i].dbl)
      begin
        regWrite(REG_BUFFER, ~rows[i].data);
        regWrite(REG_CTRL_TWO, 8'h02);
        regRead(REG_CTRL_TWO, rd);
        chk({7'h0, rd[RESTART_BIT]}, 8'h00);
        regRead(REG_STATUS, rd);
        chk({7'h0, rd[WRITE_COLLISION_FLAG_BIT]}, 8'h01);
      end
      waitFlag(IRQ_BIT);
      regRead(REG_STATUS, rd);
      chk({7'h0, rd[BF_BIT]}, 8'h00);
      regRead(REG_CTRL_TWO, rd);
      chk({7'h0, rd[PEER_ACK_BIT]}, {7'h0, ~rows[i].ack});
      chk(rxByte, rows[i].data);
      chk({7'h0, sclOe}, 8'h01);
    end
    // Receive path: address, then three bytes, only the first one read
    readOn <= 1'b1;
    ackOn <= 1'b1;
    regWrite(REG_STATUS, 8'h00);
    regWrite(REG_CTRL_TWO, 8'h02);
    waitFlag(IRQ_BIT);
    regWrite(REG_STATUS, 8'h00);
    regWrite(REG_BUFFER, 8'hA1);
    waitFlag(IRQ_BIT);
    regWrite(REG_STATUS, 8'h00);
    regWrite(REG_CTRL_TWO, 8'h08);
    waitFlag(IRQ_BIT);
    regRead(REG_CTRL_TWO, rd);
    chk({7'h0, rd[RECEIVE_BIT]}, 8'h00);
    regRead(REG_STATUS, rd);
    chk({7'h0, rd[BF_BIT]}, 8'h01);
    regRead(REG_BUFFER, rd);
    chk(rd, 8'h5A);
    regRead(REG_STATUS, rd);
    chk({7'h0, rd[BF_BIT]}, 8'h00);
    regWrite(REG_STATUS, 8'h00);
    regWrite(REG_CTRL_TWO, 8'h08);
    waitFlag(IRQ_BIT);
    regWrite(REG_STATUS, 8'h01);
    regWrite(REG_CTRL_TWO, 8'h08);
    waitFlag(IRQ_BIT);
    regRead(REG_STATUS, rd);
    chk({7'h0, rd[OVF_BIT]}, 8'h01);
    // Disable, then a start against a clock held low
    regWrite(REG_ENABLE, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({6'h0, sclOe, sdaOe}, 8'h00);
    holdScl <= 1'b1;
    regWrite(REG_ENABLE, 8'h01);
    regWrite(REG_STATUS, 8'h00);
    regWrite(REG_CTRL_TWO, 8'h01);
    waitFlag(BCOL_BIT);
    regRead(REG_CTRL_TWO, rd);
    chk({7'h0, rd[START_BIT]}, 8'h00);
    chk({7'h0, sdaOe}, 8'h00);
    holdScl <= 1'b0;
    readOn <= 1'b0;
    resetCheck();
    end_of_test();
  end
endmodule
